// ---- inc/fpc_cfg.svh ----
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
// address and data widths of the flash pins, and the sector index width
`define FPC_ADDR_W 20
`define FPC_DATA_W 16
`define FPC_SECT_W 6
// clock period and pin timing, times in ns
`define FPC_CLK_NS 25
`define FPC_ACC_NS 70
`define FPC_CE_NS 70
`define FPC_RP_NS 500
`define FPC_RH_NS 50
`define FPC_READY_NS 20000
`define FPC_SLEEP_EXTRA_NS 30
// derived cycle counts: least times round up
`define FPC_CYC_UP(ns) (((ns) + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_ACC_CYC `FPC_CYC_UP(`FPC_ACC_NS)
`define FPC_CE_CYC `FPC_CYC_UP(`FPC_CE_NS)
`define FPC_RP_CYC `FPC_CYC_UP(`FPC_RP_NS)
`define FPC_RH_CYC `FPC_CYC_UP(`FPC_RH_NS)
`define FPC_SLEEP_CYC `FPC_CYC_UP(`FPC_ACC_NS + `FPC_SLEEP_EXTRA_NS)
`define FPC_READY_CYC `FPC_CYC_UP(`FPC_READY_NS)
`define FPC_CNT_W 16
// sector map fields of the top-boot layout
`define FPC_TOP_HI 19
`define FPC_TOP_LO 15
`define FPC_BOOT_HI 14
`define FPC_BOOT_LO 12
`define FPC_TOP_BLOCK 5'h1F
`define FPC_SECT_HALF 6'h1F
`define FPC_SECT_8K_A 6'h20
`define FPC_SECT_8K_B 6'h21
`define FPC_LAST_SECT 6'h22
`define FPC_STATUS_BITS 8
`endif

// ---- inc/fpc_pkg.sv ----
`include "fpc_cfg.svh"
package fpc_pkg;
    // host side sequencer states
    typedef enum logic [2:0] {
        FPC_CLEAR = 3'b000,
        FPC_POST = 3'b001,
        FPC_IDLE = 3'b010,
        FPC_READ = 3'b011,
        FPC_WRITE = 3'b100,
        FPC_WREC = 3'b101
    } fpc_state_e;
    // pin bundle driven toward the flash
    typedef struct packed {
        logic chip_sel_n;
        logic out_gate_n;
        logic wr_strobe_n;
        logic clear_n;
        logic byte_mode_n;
        logic [`FPC_ADDR_W-1:0] addr;
    } fpc_pins_s;
    // user request
    typedef struct packed {
        logic write;
        logic [`FPC_ADDR_W-1:0] addr;
        logic lsb;
        logic [`FPC_DATA_W-1:0] wdata;
    } fpc_req_s;
endpackage

// ---- src/fpc_sector_decode.sv ----
`timescale 1ns/1ps
`include "fpc_cfg.svh"
// maps a word address to its top-boot sector index
module fpc_sector_decode (
    // address
    input wire logic [`FPC_ADDR_W-1:0] addr_in,
    // result
    output logic [`FPC_SECT_W-1:0] sector_index_out
);
    logic [4:0] top_w;
    logic [2:0] boot_w;
    assign top_w = addr_in[`FPC_TOP_HI:`FPC_TOP_LO];
    assign boot_w = addr_in[`FPC_BOOT_HI:`FPC_BOOT_LO];
    // 64k sectors below the boot block, small ones inside it
    always_comb begin
        if (top_w != `FPC_TOP_BLOCK) begin
            sector_index_out = {1'b0, top_w};
        end else if (!boot_w[2]) begin
            sector_index_out = `FPC_SECT_HALF;
        end else if (boot_w[1]) begin
            sector_index_out = `FPC_LAST_SECT;
        end else begin
            sector_index_out = boot_w[0] ? `FPC_SECT_8K_B : `FPC_SECT_8K_A;
        end
    end
endmodule

// ---- src/fpc_host.sv ----
`timescale 1ns/1ps
`include "fpc_cfg.svh"
module fpc_host #(
    parameter int READY_CYC = `FPC_READY_CYC,
    parameter int ACC_CYC = `FPC_ACC_CYC,
    parameter int CE_CYC = `FPC_CE_CYC
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // user side
    input wire logic req_valid_in,
    input wire fpc_pkg::fpc_req_s req_in,
    input wire logic byte_mode_in,
    input wire logic clear_req_in,
    output logic req_ready_out,
    output logic rd_valid_out,
    output logic [`FPC_DATA_W-1:0] rd_data_out,
    output logic [`FPC_SECT_W-1:0] sector_index_out,
    output logic busy_out,
    output logic clear_done_out,
    // flash pins
    output fpc_pkg::fpc_pins_s pins_out,
    input wire logic [`FPC_DATA_W-1:0] dq_in,
    output logic [`FPC_DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    input wire logic ready_busy_in
);
    fpc_pkg::fpc_state_e state_r;
    logic [`FPC_CNT_W-1:0] cnt_r;
    logic [2:0] rb_sync_r;
    logic rb_r;
    logic ce_idle_r;
    logic [`FPC_SECT_W-1:0] sect_w;
    logic [`FPC_ADDR_W-1:0] dec_addr_w;

    // three-stage synchroniser; level changes once stages two and three agree
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rb_sync_r <= 3'h0;
            rb_r <= 1'b0;
        end else begin
            rb_sync_r <= {rb_sync_r[1:0], ready_busy_in};
            if (rb_sync_r[1] == rb_sync_r[2]) begin
                rb_r <= rb_sync_r[2];
            end
        end
    end

    // sector of the request, for erase bookkeeping upstream
    assign dec_addr_w = req_in.addr;
    fpc_sector_decode i_fpc_sector_decode (
        .addr_in(dec_addr_w),
        .sector_index_out(sect_w)
    );

    // main sequencer; the clear pulse starts after reset and on a clear request in idle
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= fpc_pkg::FPC_CLEAR;
            cnt_r <= '0;
            pins_out <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, wr_strobe_n: 1'b1,
                          clear_n: 1'b0, byte_mode_n: 1'b1, addr: '0};
            dq_out <= '0;
            dq_oe_out <= 1'b0;
            req_ready_out <= 1'b0;
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
            sector_index_out <= '0;
            clear_done_out <= 1'b0;
            ce_idle_r <= 1'b1;
        end else begin
            rd_valid_out <= 1'b0;
            clear_done_out <= 1'b0;
            cnt_r <= cnt_r + 1'b1;
            case (state_r)
                fpc_pkg::FPC_CLEAR: begin
                    // no access while clear is low
                    pins_out.clear_n <= 1'b0;
                    pins_out.chip_sel_n <= 1'b1;
                    dq_oe_out <= 1'b0;
                    req_ready_out <= 1'b0;
                    if (cnt_r >= `FPC_CNT_W'(`FPC_RP_CYC - 1)) begin
                        pins_out.clear_n <= 1'b1;
                        cnt_r <= '0;
                        state_r <= fpc_pkg::FPC_POST;
                    end
                end
                fpc_pkg::FPC_POST: begin
                    // wait post-clear delay, and ready/busy high if a clear hit an
                    // embedded operation, bounded by the embedded clear time
                    if (cnt_r >= `FPC_CNT_W'(`FPC_RH_CYC - 1)
                        && (rb_r || cnt_r >= `FPC_CNT_W'(READY_CYC - 1))) begin
                        clear_done_out <= 1'b1;
                        req_ready_out <= 1'b1;
                        ce_idle_r <= 1'b1;
                        state_r <= fpc_pkg::FPC_IDLE;
                    end
                end
                fpc_pkg::FPC_IDLE: begin
                    // deselected with clear high is standby; a running operation
                    // carries on, so the host only watches ready/busy
                    pins_out.chip_sel_n <= 1'b1;
                    pins_out.out_gate_n <= 1'b1;
                    pins_out.wr_strobe_n <= 1'b1;
                    dq_oe_out <= 1'b0;
                    if (clear_req_in) begin
                        // pin drops on this edge so the low time spans the whole count
                        pins_out.clear_n <= 1'b0;
                        req_ready_out <= 1'b0;
                        cnt_r <= '0;
                        state_r <= fpc_pkg::FPC_CLEAR;
                    end else if (req_valid_in) begin
                        req_ready_out <= 1'b0;
                        cnt_r <= '0;
                        sector_index_out <= sect_w;
                        pins_out.byte_mode_n <= ~byte_mode_in;
                        pins_out.addr <= req_in.addr;
                        pins_out.chip_sel_n <= 1'b0;
                        if (req_in.write) begin
                            // strobe low, gate high for a write
                            pins_out.wr_strobe_n <= 1'b0;
                            dq_out <= byte_mode_in ? {req_in.lsb, 7'h00, req_in.wdata[7:0]}
                                                   : req_in.wdata;
                            dq_oe_out <= 1'b1;
                            state_r <= fpc_pkg::FPC_WRITE;
                        end else begin
                            // gate low, strobe high for a read
                            pins_out.out_gate_n <= 1'b0;
                            // dq_oe_out covers the data lanes only; in byte mode bit 15
                            // is an address input of the flash and is always driven
                            if (byte_mode_in) begin
                                dq_out <= {req_in.lsb, 15'h0000}; // extra byte-select bit
                                dq_oe_out <= 1'b0;
                            end
                            state_r <= fpc_pkg::FPC_READ;
                        end
                    end
                end
                fpc_pkg::FPC_READ: begin
                    // from standby select access time, else address access time
                    if (cnt_r >= `FPC_CNT_W'((ce_idle_r ? CE_CYC : ACC_CYC) - 1)) begin
                        // during an operation this byte is status, not array data
                        rd_data_out <= pins_out.byte_mode_n ? dq_in
                                       : {8'h00, dq_in[`FPC_STATUS_BITS-1:0]};
                        rd_valid_out <= 1'b1;
                        req_ready_out <= 1'b1;
                        ce_idle_r <= 1'b1;
                        state_r <= fpc_pkg::FPC_IDLE;
                    end
                end
                fpc_pkg::FPC_WRITE: begin
                    if (cnt_r >= `FPC_CNT_W'(ACC_CYC - 1)) begin
                        pins_out.wr_strobe_n <= 1'b1;
                        cnt_r <= '0;
                        state_r <= fpc_pkg::FPC_WREC;
                    end
                end
                fpc_pkg::FPC_WREC: begin
                    // one cycle of data hold after the strobe rises
                    dq_oe_out <= 1'b0;
                    pins_out.chip_sel_n <= 1'b1;
                    req_ready_out <= 1'b1;
                    state_r <= fpc_pkg::FPC_IDLE;
                end
                default: begin
                    state_r <= fpc_pkg::FPC_CLEAR;
                end
            endcase
        end
    end

    // ready/busy low means an embedded operation; a cut one must be reissued
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= ~rb_r;
        end
    end

    // the clear pulse stays low for at least 8 cycles after it falls
    property p_clear_width;
        @(posedge clk_sys_in) disable iff (rst_in)
        $fell(pins_out.clear_n) |-> !pins_out.clear_n [*8];
    endproperty
    a_clear_width: assert property (p_clear_width) else $error("clear pulse short");

    // cycles the clear pin has been low, so the full width can be checked
    logic [`FPC_CNT_W-1:0] clr_low_r;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            clr_low_r <= '0;
        end else if (pins_out.clear_n) begin
            clr_low_r <= '0;
        end else begin
            clr_low_r <= clr_low_r + 1'b1;
        end
    end

    // a clear pulse ends only after the whole minimum width
    property p_clear_len;
        @(posedge clk_sys_in) disable iff (rst_in)
        $rose(pins_out.clear_n) |-> clr_low_r >= `FPC_CNT_W'(`FPC_RP_CYC);
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear pulse below minimum");

    // no select while clear is low
    property p_no_access_in_clear;
        @(posedge clk_sys_in) disable iff (rst_in)
        !pins_out.clear_n |-> pins_out.chip_sel_n;
    endproperty
    a_no_access_in_clear: assert property (p_no_access_in_clear) else $error("access in clear");

    // read pin levels
    property p_read_levels;
        @(posedge clk_sys_in) disable iff (rst_in)
        state_r == fpc_pkg::FPC_READ |-> !pins_out.chip_sel_n && !pins_out.out_gate_n
            && pins_out.wr_strobe_n && !dq_oe_out;
    endproperty
    a_read_levels: assert property (p_read_levels) else $error("bad read levels");

    // write pin levels
    property p_write_levels;
        @(posedge clk_sys_in) disable iff (rst_in)
        state_r == fpc_pkg::FPC_WRITE |-> !pins_out.chip_sel_n && pins_out.out_gate_n
            && !pins_out.wr_strobe_n;
    endproperty
    a_write_levels: assert property (p_write_levels) else $error("bad write levels");

    // no read before the post-clear delay
    property p_post_clear;
        @(posedge clk_sys_in) disable iff (rst_in)
        $rose(pins_out.clear_n) |-> pins_out.out_gate_n [*2];
    endproperty
    a_post_clear: assert property (p_post_clear) else $error("read too soon");

    // a read waits the select access time before data is taken
    property p_read_wait;
        @(posedge clk_sys_in) disable iff (rst_in)
        $fell(pins_out.out_gate_n) |-> !rd_valid_out [*3];
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read data early");

    // scenario covers
    c_read: cover property (@(posedge clk_sys_in) disable iff (rst_in) rd_valid_out);
    c_write: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        state_r == fpc_pkg::FPC_WREC);
    c_clear_busy: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        state_r == fpc_pkg::FPC_POST && busy_out);
endmodule

// ---- verif/fpc_flash_model.sv ----
`timescale 1ns/1ps
`include "fpc_cfg.svh"
// behavioural flash; the array word is a fixed function of its address
module fpc_flash_model #(
    parameter int OP_NS = 3000,
    parameter int CLR_NS = 1500,
    parameter logic [7:0] STAT = 8'h4C
) (
    // flash pins
    input wire fpc_pkg::fpc_pins_s pins_in,
    input wire logic lsb_in,
    output logic [15:0] dq_out,
    output logic ready_busy_out
);
    longint op_end = 0;
    longint rdy_t = 0;
    longint cs_t = 0;
    longint ad_t = 0;
    logic [15:0] last = 16'h0000;
    logic [15:0] w;
    logic op;
    // a write starts an operation that runs on after deselect
    always @(posedge pins_in.wr_strobe_n)
        if (pins_in.clear_n && !pins_in.chip_sel_n) op_end = $time + OP_NS;
    // clear aborts the operation; busy lasts the clear time only if one ran
    always @(negedge pins_in.clear_n) begin
        if ($time < op_end) rdy_t = $time + CLR_NS;
        op_end = 0;
    end
    always @(negedge pins_in.chip_sel_n) cs_t = $time;
    always @(pins_in.addr) ad_t = $time;
    // polled each ns; unsettled or released lines show the inverse of the last value
    always begin
        #1;
        op = $time < op_end;
        ready_busy_out = !(op || $time < rdy_t);
        w = op ? {8'h00, STAT} : pins_in.addr[15:0] ^ 16'h5A3C;
        if (!pins_in.byte_mode_n) w = {~last[15:8], lsb_in ? w[15:8] : w[7:0]};
        if (pins_in.clear_n && !pins_in.chip_sel_n && !pins_in.out_gate_n &&
            $time >= cs_t + `FPC_CE_NS && $time >= ad_t + `FPC_ACC_NS) begin
            last = w;
            dq_out = w;
        end else dq_out = ~last;
    end
endmodule

// ---- verif/fpc_host_tb.sv ----
`timescale 1ns/1ps
`include "fpc_cfg.svh"
module fpc_host_tb;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    fpc_pkg::fpc_req_s req_in = '0;
    logic byte_mode_in = 1'b0;
    logic clear_req_in = 1'b0;
    logic req_ready_out, rd_valid_out, busy_out, clear_done_out, dq_oe_out, rdy;
    logic [15:0] rd_data_out, dq_out, fl_dq, d;
    logic [5:0] sector_index_out;
    fpc_pkg::fpc_pins_s pins_out;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    int c;
    always #12.5 clk_sys_in = ~clk_sys_in;
    fpc_host i_fpc_host (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .byte_mode_in(byte_mode_in), .clear_req_in(clear_req_in),
        .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
        .sector_index_out(sector_index_out), .busy_out(busy_out),
        .clear_done_out(clear_done_out), .pins_out(pins_out), .dq_in(fl_dq), .dq_out(dq_out),
        .dq_oe_out(dq_oe_out), .ready_busy_in(rdy));
    // in byte mode bit 15 is the extra byte-select address; otherwise lsb_in takes the inverse of the flash's bit 15
    fpc_flash_model i_fpc_flash_model (.pins_in(pins_out),
        .lsb_in(!pins_out.byte_mode_n ? dq_out[15] : ~fl_dq[15]), .dq_out(fl_dq),
        .ready_busy_out(rdy));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d compares %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // waits for idle, hands over one request, checks the strobes mid-cycle
    task automatic issue(input logic wr, input logic [19:0] a, input logic lb, input logic bm);
        for (n = 0; n < 400 && req_ready_out !== 1'b1; n++) @(negedge clk_sys_in);
        req_in = '{wr, a, lb, 16'hC3A5};
        byte_mode_in = bm;
        req_valid_in = 1'b1;
        @(negedge clk_sys_in);
        req_valid_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        chk({13'h0000, pins_out.chip_sel_n, pins_out.out_gate_n, pins_out.wr_strobe_n},
            wr ? 16'h0002 : 16'h0001);
        if (wr) chk(dq_oe_out === 1'b1 ? dq_out : 16'hxxxx, 16'hC3A5);
    endtask
    task automatic rd(input logic [19:0] a, input logic lb, input logic bm);
        issue(1'b0, a, lb, bm);
        for (n = 0; n < 20 && rd_valid_out !== 1'b1; n++) @(negedge clk_sys_in);
        d = (rd_valid_out === 1'b1) ? rd_data_out : 16'hxxxx;
    endtask
    task automatic do_clear;
        for (n = 0; n < 400 && req_ready_out !== 1'b1; n++) @(negedge clk_sys_in);
        clear_req_in = 1'b1;
        @(negedge clk_sys_in);
        clear_req_in = 1'b0;
        for (c = 0; c < 1000 && clear_done_out !== 1'b1; c++) @(negedge clk_sys_in);
    endtask
    task automatic wait_busy(input logic v, input int lim);
        for (n = 0; n < lim && busy_out !== v; n++) @(negedge clk_sys_in);
    endtask
    function automatic logic [15:0] sect(input logic [19:0] a);
        if (a[19:15] != 5'h1F) return {11'h000, a[19:15]};
        if (!a[14]) return 16'h001F;
        if (!a[13]) return 16'h0020 + a[12];
        return 16'h0022;
    endfunction
    // word reads across the boot corner of the map, no command after clear
    task automatic t_sect;
        logic [19:0] t [9] = '{20'h0_0000, 20'h7_FFFF, 20'hF_7FFF, 20'hF_8000, 20'hF_BFFF,
            20'hF_C000, 20'hF_D000, 20'hF_E000, 20'hF_FFFF};
        foreach (t[i]) begin
            rd(t[i], 1'b0, 1'b0);
            chk(d, t[i][15:0] ^ 16'h5A3C);
            chk({10'h000, sector_index_out}, sect(t[i]));
        end
    endtask
    task automatic t_byte;
        for (int b = 0; b < 2; b++) begin
            rd(20'h0_1234, b[0], 1'b1);
            chk({8'h00, d[7:0]}, b ? 16'h0048 : 16'h0008);
        end
    endtask
    // status during an operation that keeps running while deselected
    task automatic t_status;
        issue(1'b1, 20'h0_0100, 1'b0, 1'b0);
        wait_busy(1'b1, 12);
        chk({15'h0000, busy_out}, 16'h0001);
        rd(20'h0_0100, 1'b0, 1'b0);
        chk({8'h00, d[7:0]}, 16'h004C);
        wait_busy(1'b0, 200);
        chk({15'h0000, busy_out}, 16'h0000);
    endtask
    // clear cuts a running operation; ready/busy holds the clear back
    task automatic t_clr_op;
        issue(1'b1, 20'h0_0200, 1'b0, 1'b0);
        wait_busy(1'b1, 12);
        do_clear;
        chk({15'h0000, c >= 55 && c < 1000}, 16'h0001);
        chk({15'h0000, busy_out}, 16'h0000);
        rd(20'h0_0200, 1'b0, 1'b0);
        chk(d, 16'h583C);
        issue(1'b1, 20'h0_0200, 1'b0, 1'b0);
        wait_busy(1'b1, 12);
        chk({15'h0000, busy_out}, 16'h0001);
        wait_busy(1'b0, 200);
    endtask
    task automatic t_clr_idle;
        do_clear;
        chk({15'h0000, c >= `FPC_RP_CYC && c <= 40}, 16'h0001);
    endtask
    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        for (c = 0; c < 1000 && clear_done_out !== 1'b1; c++) @(negedge clk_sys_in);
        chk({15'h0000, c < 1000}, 16'h0001);
        t_sect();
        t_byte();
        t_status();
        t_clr_op();
        t_clr_idle();
        test_done();
    end
endmodule
